// ===== core/remote_receiver.sv
// Purpose: pulse-width remote control receiver with register port
// Assumes: I_SAMPLE_CLK is a slow 32.768kHz square wave, sampled as a plain input
// Notes: phase-method decoding not built; its select bit is only stored
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "remote_receiver_cfg.svh"

module remote_receiver (
  // clock, enable and reset
  input wire logic I_REF_CLK,
  input wire logic I_CE,
  input wire logic I_RST,
  // pins
  input wire logic I_SAMPLE_CLK,
  input wire logic I_RMC_IN,
  // register port
  input wire logic [`RR_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // event
  output logic O_IRQ
);
  remote_receiver_pkg::leader_cfg_s lead_reg;
  remote_receiver_pkg::ctl2_s ctl_reg;
  remote_receiver_pkg::status_s stat_reg;
  remote_receiver_pkg::rx_state_e state_reg;
  logic [6:0] datl_reg;
  logic [6:0] dath_reg;
  logic invert_reg;
  logic [3:0] nc_reg;
  logic [`RR_BUF_BITS-1:0] rx_buf_reg;
  logic [`RR_BUF_BITS-1:0] shift_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] rmc_sync_reg;
  logic filt_reg;
  logic [3:0] run_reg;
  logic [7:0] cyc_reg;
  logic [7:0] low_reg;
  logic [7:0] lowm_reg;
  logic [6:0] bits_reg;
  logic irq_reg;
  logic tick;
  logic sample_in;
  logic accept;
  logic fall;
  logic rise;
  logic [7:0] cyc_meas;
  logic [7:0] low_meas;
  logic leader_ok;
  logic as_data;
  logic max_evt;
  logic low_evt;
  logic bit_val;
  logic edge_irq;
  logic lead_irq;
  logic done;
  logic [6:0] bits_next;

  // slow clock edge and input synchronisers
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_sync_reg <= 3'h0;
      rmc_sync_reg <= 2'h3;
    end else if (I_CE) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], I_SAMPLE_CLK};
      rmc_sync_reg <= {rmc_sync_reg[0], I_RMC_IN};
    end
  end
  assign tick = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sample_in = rmc_sync_reg[1] ^ invert_reg;

  // noise filter
  assign accept = tick && (sample_in != filt_reg) && ((nc_reg == 4'h0) ||
                  ({1'b0, run_reg} + 5'h01 >= {1'b0, nc_reg}));
  assign fall = accept && !sample_in;
  assign rise = accept && sample_in;
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      filt_reg <= 1'b1;
      run_reg <= 4'h0;
    end else if (I_CE && tick) begin
      if (accept) begin
        filt_reg <= sample_in;
        run_reg <= 4'h0;
      end else if (sample_in != filt_reg) begin
        run_reg <= run_reg + 4'h1;
      end else begin
        run_reg <= 4'h0;
      end
    end
  end

  // width measurement in sample periods
  assign cyc_meas = (cyc_reg == 8'hFF) ? 8'hFF : cyc_reg + 8'h01;
  assign low_meas = (low_reg == 8'hFF) ? 8'hFF : low_reg + 8'h01;
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cyc_reg <= 8'h00;
      low_reg <= 8'h00;
      lowm_reg <= 8'h00;
    end else if (I_CE && tick) begin
      cyc_reg <= fall ? 8'h00 : cyc_meas;
      if (fall) begin
        low_reg <= 8'h00;
      end else if (!filt_reg) begin
        low_reg <= low_meas;
      end
      if (rise) begin
        lowm_reg <= low_meas;
      end
    end
  end

  // leader check, decode and completion
  assign leader_ok = state_reg == remote_receiver_pkg::ST_LEADER && fall &&
                     cyc_meas > lead_reg.lcmin && cyc_meas < lead_reg.lcmax &&
                     (lead_reg.llmax == 8'h00 ||
                      (lowm_reg > lead_reg.llmin && lowm_reg < lead_reg.llmax));
  assign as_data = state_reg == remote_receiver_pkg::ST_LEADER && fall && !leader_ok &&
                   ctl_reg.ld && lowm_reg < lead_reg.llmax;
  assign bit_val = cyc_meas >= {1'b0, datl_reg};
  assign max_evt = state_reg == remote_receiver_pkg::ST_DATA && tick && !fall &&
                   ctl_reg.dmax != `RR_TRIGGER_OFF && cyc_meas >= ctl_reg.dmax;
  assign low_evt = state_reg == remote_receiver_pkg::ST_DATA && tick && !fall &&
                   !max_evt && !filt_reg && ctl_reg.ll != `RR_TRIGGER_OFF &&
                   low_meas > ctl_reg.ll;
  assign done = max_evt || low_evt;
  assign edge_irq = ctl_reg.edien && fall && (state_reg == remote_receiver_pkg::ST_DATA
                    || as_data);
  assign lead_irq = ctl_reg.lien && leader_ok;
  assign bits_next = (bits_reg == `RR_COUNT_MAX) ? bits_reg : bits_reg + 7'h01;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= remote_receiver_pkg::ST_OFF;
      bits_reg <= 7'h00;
      shift_reg <= '0;
    end else if (I_CE) begin
      if (!ctl_reg.ren) begin
        state_reg <= remote_receiver_pkg::ST_OFF;
        bits_reg <= 7'h00;
        shift_reg <= '0;
      end else begin
        case (state_reg)
          remote_receiver_pkg::ST_OFF: begin
            state_reg <= remote_receiver_pkg::ST_WAIT;
          end
          remote_receiver_pkg::ST_WAIT: begin
            if (fall && lead_reg.lcmax == 8'h00) begin
              state_reg <= remote_receiver_pkg::ST_DATA;
            end else if (fall) begin
              state_reg <= remote_receiver_pkg::ST_LEADER;
            end
            bits_reg <= 7'h00;
            shift_reg <= '0;
          end
          remote_receiver_pkg::ST_LEADER: begin
            if (leader_ok) begin
              state_reg <= remote_receiver_pkg::ST_DATA;
            end else if (as_data) begin
              state_reg <= remote_receiver_pkg::ST_DATA;
              shift_reg[0] <= bit_val;
              bits_reg <= 7'h01;
            end else if (tick && !fall && cyc_meas >= lead_reg.lcmax) begin
              state_reg <= remote_receiver_pkg::ST_WAIT;
            end
          end
          remote_receiver_pkg::ST_DATA: begin
            if (done) begin
              state_reg <= remote_receiver_pkg::ST_WAIT;
            end else if (fall) begin
              if (bits_reg < 7'h48) begin
                shift_reg[bits_reg] <= bit_val;
              end
              bits_reg <= bits_next;
            end
          end
          default: begin
            state_reg <= remote_receiver_pkg::ST_OFF;
          end
        endcase
      end
    end
  end

  // status, buffers and interrupt pulse
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      stat_reg <= '0;
      rx_buf_reg <= '0;
      irq_reg <= 1'b0;
    end else if (I_CE) begin
      irq_reg <= lead_irq || edge_irq || done;
      if (leader_ok) begin
        stat_reg.leader_det <= 1'b1;
      end else if (as_data || (state_reg == remote_receiver_pkg::ST_WAIT && fall &&
                   lead_reg.lcmax == 8'h00)) begin
        stat_reg.leader_det <= 1'b0;
      end
      if (lead_irq || edge_irq || done) begin
        stat_reg.leader_if <= lead_irq;
        stat_reg.low_if <= low_evt;
        stat_reg.max_if <= max_evt;
        stat_reg.edge_if <= edge_irq;
      end
      if (done && ctl_reg.ren) begin
        stat_reg.count <= bits_reg;
        rx_buf_reg <= shift_reg;
      end
    end
  end
  assign O_IRQ = irq_reg;

  // register writes
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      lead_reg <= `RR_RESET_WORD;
      ctl_reg <= '0;
      datl_reg <= 7'h00;
      dath_reg <= 7'h00;
      invert_reg <= 1'b0;
      nc_reg <= 4'h0;
    end else if (I_CE && I_WR) begin
      case (I_ADDR)
        `RR_OFF_LEADER_TIMING: lead_reg <= I_WDATA;
        `RR_OFF_CONTROL_TWO: begin
          ctl_reg <= {I_WDATA[`RR_CTL2_REN_BIT], I_WDATA[`RR_CTL2_LIEN_BIT],
                      I_WDATA[`RR_CTL2_EDIEN_BIT], I_WDATA[`RR_CTL2_LD_BIT],
                      I_WDATA[`RR_CTL2_PHM_BIT], I_WDATA[15:0]};
        end
        `RR_OFF_BIT_THRESHOLD: begin
          datl_reg <= I_WDATA[6:0];
          dath_reg <= I_WDATA[14:8];
        end
        `RR_OFF_FILTER_POLARITY: begin
          invert_reg <= I_WDATA[`RR_FPC_INVERT_BIT];
          nc_reg <= I_WDATA[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // register reads, one cycle later
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= `RR_RESET_WORD;
    end else if (I_CE) begin
      O_RDATA <= `RR_RESET_WORD;
      if (I_RD) begin
        case (I_ADDR)
          `RR_OFF_LEADER_TIMING: O_RDATA <= lead_reg;
          `RR_OFF_CONTROL_TWO: begin
            O_RDATA <= {ctl_reg.ren, 3'h0, ctl_reg.lien, ctl_reg.edien, ctl_reg.ld,
                        ctl_reg.phm, 8'h00, ctl_reg.ll, ctl_reg.dmax};
          end
          `RR_OFF_BIT_THRESHOLD: O_RDATA <= {17'h0, dath_reg, 1'b0, datl_reg};
          `RR_OFF_FILTER_POLARITY: O_RDATA <= {24'h0, invert_reg, 3'h0, nc_reg};
          `RR_OFF_STATUS: O_RDATA <= {16'h0, stat_reg[11:8], 4'h0, stat_reg[7:0]};
          `RR_OFF_BUFFER_A: O_RDATA <= rx_buf_reg[31:0];
          `RR_OFF_BUFFER_B: O_RDATA <= rx_buf_reg[63:32];
          `RR_OFF_BUFFER_C: O_RDATA <= {24'h0, rx_buf_reg[71:64]};
          default: O_RDATA <= `RR_RESET_WORD;
        endcase
      end
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  chk_filter_bypass: assert property (I_CE && tick && nc_reg == 4'h0 |=>
    filt_reg == $past(sample_in)) else $error("filter bypass failed");
  chk_filter_hold: assert property (I_CE && tick && nc_reg != 4'h0 &&
    {1'b0, run_reg} + 5'h01 < {1'b0, nc_reg} |=> $stable(filt_reg))
    else $error("filter changed early");
  chk_leader_flag: assert property (I_CE && leader_ok && ctl_reg.ren |=>
    stat_reg.leader_det && state_reg == remote_receiver_pkg::ST_DATA)
    else $error("leader not recorded");
  chk_leader_irq: assert property (I_CE && leader_ok && ctl_reg.lien |=>
    O_IRQ && stat_reg.leader_if) else $error("leader irq missing");
  chk_no_leader_irq: assert property (I_CE && (as_data || (fall &&
    state_reg == remote_receiver_pkg::ST_WAIT && lead_reg.lcmax == 8'h00)) |=>
    !(O_IRQ && stat_reg.leader_if)) else $error("leader irq without leader");
  chk_edge_irq: assert property (I_CE && fall && ctl_reg.edien &&
    state_reg == remote_receiver_pkg::ST_DATA |=> O_IRQ && stat_reg.edge_if)
    else $error("edge irq missing");
  chk_cycle_done: assert property (I_CE && max_evt && ctl_reg.ren |=>
    stat_reg.max_if && !stat_reg.low_if && state_reg == remote_receiver_pkg::ST_WAIT)
    else $error("cycle timeout not handled");
  chk_count_frozen: assert property (I_CE && !done |=> $stable(stat_reg.count))
    else $error("count changed during reception");
  chk_disable_stop: assert property (I_CE && !ctl_reg.ren |=>
    state_reg == remote_receiver_pkg::ST_OFF && bits_reg == 7'h00)
    else $error("disable did not stop");
  chk_low_done: assert property (I_CE && low_evt && ctl_reg.ren |=>
    stat_reg.low_if && !stat_reg.max_if && state_reg == remote_receiver_pkg::ST_WAIT)
    else $error("low width timeout not handled");
  chk_count_load: assert property (I_CE && done && ctl_reg.ren |=>
    stat_reg.count == $past(bits_reg)) else $error("bit count not loaded");
  chk_status_ro: assert property (I_CE && I_WR && I_ADDR == `RR_OFF_STATUS && !fall &&
    !done |=> $stable(stat_reg)) else $error("status took a write");
  chk_reserved_zero: assert property (I_CE && I_RD && I_ADDR == `RR_OFF_FILTER_POLARITY |=>
    O_RDATA[31:8] == 24'h000000 && O_RDATA[6:4] == 3'h0) else $error("reserved bits set");
  chk_bit_store: assert property (I_CE && ctl_reg.ren && fall && bits_reg < 7'h48 &&
    state_reg == remote_receiver_pkg::ST_DATA |=> shift_reg[$past(bits_reg)] == $past(bit_val))
    else $error("data bit not stored");
  cov_max_done: cover property (max_evt);
  cov_long_frame: cover property (done && bits_reg > 7'h48);
  cov_leader: cover property (leader_ok && ctl_reg.lien);
  cov_low_done: cover property (low_evt);
  cov_no_leader: cover property (as_data);
endmodule

// ===== dv/remote_receiver_tb_top.sv
// Purpose: self-checking bench of the remote receiver
// Assumes: sample clock shortened to 8 system clocks a period
// Notes: expected buffers and status built from the sent bit pattern
`timescale 1ns/1ps
module remote_receiver_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk = 1'b0;
  logic rmc;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  int err_count = 0;
  int checked = 0;
  int irq_seen = 0;
  int seed = 32'ha26eb342;
  int irq0;
  int nb;
  logic ce = 1'b1;
  always #2 clk = ~clk;
  always #16 sclk = ~sclk;
  always @(posedge clk) begin
    if (irq === 1'b1) irq_seen++;
  end
  remote_receiver uut (.I_REF_CLK(clk), .I_CE(ce), .I_RST(rst), .I_SAMPLE_CLK(sclk),
    .I_RMC_IN(rmc), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_IRQ(irq));
  rmc_remote_model u_remote (.i_sclk(sclk), .o_line(rmc));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // one frame with its expectations on status, buffers and interrupt count
  task automatic run(input bit lead, input int n, input bit low_end, input bit edien,
    input bit lien);
    logic [79:0] b;
    logic [71:0] eb;
    logic [31:0] est;
    int base;
    b = 80'({$random(seed), $random(seed), $random(seed)});
    eb = '0;
    for (int i = 0; i < 72; i++) begin
      if (i < n) eb[i] = b[i];
    end
    wreg(8'h04, 32'h8000_0600 | (32'(lien) << 27) | (32'(edien) << 26)
      | (lead ? 32'h0000_0000 : 32'h0200_0000)
      | (low_end ? 32'h0000_00FF : 32'h0000_000C));
    base = irq_seen;
    u_remote.frame(lead, n, b, low_end);
    repeat (80) @(posedge clk);
    est = 32'(n > 127 ? 127 : n) | (lead ? 32'h80 : 32'h0) | (low_end ? 32'h4000 : 32'h2000);
    rchk(8'h10, est);
    if (n <= 72) begin
      rchk(8'h14, eb[31:0]);
      rchk(8'h18, eb[63:32]);
      rchk(8'h1C, {24'h0, eb[71:64]});
    end
    check(32'(irq_seen - base), 32'((lead && lien) + (edien ? n : 0) + 1));
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    err_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h0C, 32'h0000_0000);
    rchk(8'h10, 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    wreg(8'h0C, 32'h0000_0085);
    ce <= 1'b1;
    rchk(8'h0C, 32'h0000_0000);
    wreg(8'h0C, 32'hFFFF_FFFF);
    rchk(8'h0C, 32'h0000_008F);
    wreg(8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wreg(8'h00, 32'h140C_0B05);
    wreg(8'h08, 32'h0000_0008);
    wreg(8'h0C, 32'h0000_0003);
    u_remote.glitch = 1'b1;
    run(1'b1, 1, 1'b0, 1'b0, 1'b1);
    u_remote.frame(1'b1, 5, 80'h0, 1'b0);
    run(1'b1, 72, 1'b0, 1'b0, 1'b1);
    wreg(8'h0C, 32'h0000_0083);
    u_remote.set_inv(1'b1);
    repeat (30) @(negedge sclk);
    run(1'b1, 20, 1'b1, 1'b1, 1'b0);
    nb = 73 + ($unsigned($random(seed)) % 8);
    run(1'b1, nb, 1'b0, 1'b0, 1'b0);
    wreg(8'h04, 32'h8800_060C);
    fork
      u_remote.frame(1'b1, 30, 80'h0, 1'b0);
    join_none
    repeat (40) @(negedge sclk);
    irq0 = irq_seen;
    rchk(8'h10, 32'h0000_8080 | 32'(nb));
    wreg(8'h04, 32'h0800_060C);
    wait fork;
    repeat (80) @(posedge clk);
    check(32'(irq_seen - irq0), 32'h0000_0000);
    wreg(8'h00, 32'h000C_0B05);
    run(1'b0, 8, 1'b0, 1'b0, 1'b1);
    wreg(8'h00, 32'h140C_0B05);
    run(1'b0, 8, 1'b1, 1'b1, 1'b1);
    results();
  end
endmodule

// ===== dv/rmc_remote_model.sv
// Purpose: remote control transmitter model driving the receiver input pin
// Assumes: line idles high, or low once set_inv(1) has set inv; widths counted in sample clock periods
// Notes: line moves on the sample clock falling edge, away from the tick
`timescale 1ns/1ps
module rmc_remote_model (
  // sample clock
  input wire logic i_sclk,
  // pin
  output logic o_line
);
  logic inv = 1'b0;
  logic glitch = 1'b0;
  initial o_line = 1'b1;
  task automatic ticks(input int n);
    repeat (n) @(negedge i_sclk);
  endtask
  task automatic set_inv(input logic v);
    inv = v;
    o_line = ~v;
  endtask
  // one low part then one high part, optional short dip inside the high
  task automatic seg(input int lo, input int hi);
    o_line = inv;
    ticks(lo);
    o_line = ~inv;
    // long highs only, so a short bit still clears a three-sample filter
    if (glitch && hi >= 8) begin
      ticks(hi / 2);
      o_line = inv;
      ticks(1);
      o_line = ~inv;
      ticks(hi - hi / 2 - 1);
    end else begin
      ticks(hi);
    end
  endtask
  task automatic frame(input bit lead, input int n, input logic [79:0] b, input bit low_end);
    if (lead) begin
      seg(8, 8);
    end
    for (int i = 0; i < n; i++) begin
      seg(3, b[i] ? 5 : 4);
    end
    if (low_end) begin
      seg(9, 2);
    end else begin
      seg(3, 19);
    end
  endtask
endmodule

// ===== inc/remote_receiver_cfg.svh
// Purpose: offsets, field positions and reset values of the remote receiver
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
`ifndef REMOTE_RECEIVER_CFG_SVH
`define REMOTE_RECEIVER_CFG_SVH
`define RR_ADDR_W 8
`define RR_OFF_LEADER_TIMING 8'h00
`define RR_OFF_CONTROL_TWO 8'h04
`define RR_OFF_BIT_THRESHOLD 8'h08
`define RR_OFF_FILTER_POLARITY 8'h0C
`define RR_OFF_STATUS 8'h10
`define RR_OFF_BUFFER_A 8'h14
`define RR_OFF_BUFFER_B 8'h18
`define RR_OFF_BUFFER_C 8'h1C
`define RR_CTL2_PHM_BIT 24
`define RR_CTL2_LD_BIT 25
`define RR_CTL2_EDIEN_BIT 26
`define RR_CTL2_LIEN_BIT 27
`define RR_CTL2_REN_BIT 31
`define RR_FPC_INVERT_BIT 7
`define RR_TRIGGER_OFF 8'hFF
`define RR_BUF_BITS 72
`define RR_COUNT_MAX 7'h7F
`define RR_RESET_WORD 32'h0000_0000
`endif

// ===== inc/remote_receiver_pkg.sv
// Purpose: types of the remote receiver
// Assumes: nothing
// Notes: states are one-hot
package remote_receiver_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_WAIT = 4'h2,
    ST_LEADER = 4'h4,
    ST_DATA = 4'h8
  } rx_state_e;
  typedef struct packed {
    logic [7:0] lcmax;
    logic [7:0] lcmin;
    logic [7:0] llmax;
    logic [7:0] llmin;
  } leader_cfg_s;
  typedef struct packed {
    logic ren;
    logic lien;
    logic edien;
    logic ld;
    logic phm;
    logic [7:0] ll;
    logic [7:0] dmax;
  } ctl2_s;
  typedef struct packed {
    logic leader_if;
    logic low_if;
    logic max_if;
    logic edge_if;
    logic leader_det;
    logic [6:0] count;
  } status_s;
endpackage
